// file: design/shift_reg_pkg.sv
// Constants for the eight-bit bidirectional universal shift register.
// Assumes a single ref_clk domain; every input is synchronous to it.
//
// Behaviour
// - Low master clear empties all stages immediately.
// - Both selects high loads parallel inputs.
// - Low select only shifts up, right serial in.
// - High select only shifts down, left serial in.
// - Both selects low holds every stage.
// - Apart from master clear, stages change only on shift clock rise.
// - All eight stages always visible on outputs.
`default_nettype none

package shift_reg_pkg;

  // ------------------------------------------------------------
  // Geometry and reset values
  // ------------------------------------------------------------
  localparam int STAGE_COUNT = 8;
  localparam int TOP_STAGE = STAGE_COUNT - 1;
  localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
  localparam logic SHIFT_CLOCK_RESET = 1'h1;

  // ------------------------------------------------------------
  // Operating modes, indexed by {mode_select_high, mode_select_low}
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HOLD,
    MODE_UP,
    MODE_DOWN,
    MODE_LOAD
  } mode_t;

endpackage

`default_nettype wire

// file: design/clock_rise_detect.sv
// Rising-edge finder for the sampled shift clock input.
// Assumes shift_clock is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module clock_rise_detect (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Sampled clock pin
  input wire logic shift_clock,
  // One-cycle pulse on a low-to-high transition
  output logic rise
);

  logic last_level;

  // ------------------------------------------------------------
  // Previous level
  // ------------------------------------------------------------
  // Reset high so that a clock already high at release is no edge.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      last_level <= shift_reg_pkg::SHIFT_CLOCK_RESET;
    end else begin
      last_level <= shift_clock;
    end
  end

  assign rise = shift_clock & ~last_level;

endmodule

`default_nettype wire

// file: design/universal_shift_reg.sv
// Eight-bit bidirectional universal shift register with asynchronous clear.
// Assumes the mode, serial and parallel inputs and shift_clock are
// synchronous to ref_clk and steady around each shift clock rise.
`timescale 1ns/1ps
`default_nettype none

module universal_shift_reg (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Clear and shift clock pins
  input wire logic master_clear_n,
  input wire logic shift_clock,
  // Mode selects
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  // Serial inputs
  input wire logic right_serial_in,
  input wire logic left_serial_in,
  // Parallel data
  input wire logic [shift_reg_pkg::STAGE_COUNT-1:0] parallel_in,
  output logic [shift_reg_pkg::STAGE_COUNT-1:0] parallel_out
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic clear_n;
  logic rise;
  shift_reg_pkg::mode_t mode;
  logic [shift_reg_pkg::STAGE_COUNT-1:0] stage;
  logic [shift_reg_pkg::STAGE_COUNT-1:0] next_stage;

  // Either reset source empties the stages without the clock.
  assign clear_n = rstn & master_clear_n;

  assign mode = shift_reg_pkg::mode_t'({mode_select_high, mode_select_low});

  // ------------------------------------------------------------
  // Shift clock edge
  // ------------------------------------------------------------
  clock_rise_detect u_rise (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .shift_clock(shift_clock),
    .rise(rise)
  );

  // ------------------------------------------------------------
  // Next value of each stage
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < shift_reg_pkg::STAGE_COUNT; i++) begin : g_stage
      logic from_below;
      logic from_above;
      if (i == 0) begin : g_low
        assign from_below = right_serial_in;
      end else begin : g_low
        assign from_below = stage[i-1];
      end
      if (i == shift_reg_pkg::TOP_STAGE) begin : g_high
        assign from_above = left_serial_in;
      end else begin : g_high
        assign from_above = stage[i+1];
      end
      always_comb begin
        case (mode)
          shift_reg_pkg::MODE_LOAD: next_stage[i] = parallel_in[i];
          shift_reg_pkg::MODE_UP: next_stage[i] = from_below;
          shift_reg_pkg::MODE_DOWN: next_stage[i] = from_above;
          shift_reg_pkg::MODE_HOLD: next_stage[i] = stage[i];
          default: next_stage[i] = stage[i];
        endcase
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Stage flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge clear_n) begin
    if (!clear_n) begin
      stage <= shift_reg_pkg::STAGE_RESET;
    end else if (rise) begin
      stage <= next_stage;
    end
  end

  assign parallel_out = stage;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_load_edge;
    rise && mode_select_low && mode_select_high;
  endsequence

  sequence s_up_edge;
    rise && mode_select_low && !mode_select_high;
  endsequence

  sequence s_down_edge;
    rise && !mode_select_low && mode_select_high;
  endsequence

  sequence s_clock_low_two;
    !shift_clock [*2];
  endsequence

  sequence s_rise_in_clear;
    rise && !master_clear_n;
  endsequence

  sequence s_hold_edge;
    rise && !mode_select_low && !mode_select_high;
  endsequence

  sequence s_clock_high_three;
    shift_clock [*3];
  endsequence

  property p_clear_empty;
    @(posedge ref_clk) disable iff (!rstn)
      !master_clear_n |-> parallel_out == shift_reg_pkg::STAGE_RESET;
  endproperty
  a_clear_empty: assert property (p_clear_empty)
    else $error("Stages not empty while master clear is low.");

  property p_clear_release;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(master_clear_n) |-> parallel_out == shift_reg_pkg::STAGE_RESET;
  endproperty
  a_clear_release: assert property (p_clear_release)
    else $error("Stages not empty at master clear release.");

  property p_load;
    @(posedge ref_clk) disable iff (!clear_n)
      s_load_edge |=> parallel_out == $past(parallel_in);
  endproperty
  a_load: assert property (p_load)
    else $error("Parallel load did not capture the inputs.");

  property p_shift_up;
    @(posedge ref_clk) disable iff (!clear_n)
      s_up_edge |=> parallel_out ==
        {$past(parallel_out[shift_reg_pkg::TOP_STAGE-1:0]), $past(right_serial_in)};
  endproperty
  a_shift_up: assert property (p_shift_up)
    else $error("Upward shift gave a wrong result.");

  property p_shift_down;
    @(posedge ref_clk) disable iff (!clear_n)
      s_down_edge |=> parallel_out ==
        {$past(left_serial_in), $past(parallel_out[shift_reg_pkg::TOP_STAGE:1])};
  endproperty
  a_shift_down: assert property (p_shift_down)
    else $error("Downward shift gave a wrong result.");

  property p_hold;
    @(posedge ref_clk) disable iff (!clear_n)
      (!mode_select_low && !mode_select_high) |=> $stable(parallel_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Stages changed in hold mode.");

  property p_no_edge_no_change;
    @(posedge ref_clk) disable iff (!clear_n)
      !rise |=> $stable(parallel_out);
  endproperty
  a_no_edge_no_change: assert property (p_no_edge_no_change)
    else $error("Stages changed without a shift clock rise.");

  property p_clock_low_steady;
    @(posedge ref_clk) disable iff (!clear_n)
      s_clock_low_two |-> $stable(parallel_out);
  endproperty
  a_clock_low_steady: assert property (p_clock_low_steady)
    else $error("Stages changed while the shift clock stayed low.");

  property p_clear_beats_rise;
    @(posedge ref_clk) disable iff (!rstn)
      s_rise_in_clear |=> parallel_out == shift_reg_pkg::STAGE_RESET;
  endproperty
  a_clear_beats_rise: assert property (p_clear_beats_rise)
    else $error("A shift clock rise changed the stages during master clear.");

  property p_hold_edge;
    @(posedge ref_clk) disable iff (!clear_n)
      s_hold_edge |=> parallel_out == $past(parallel_out);
  endproperty
  a_hold_edge: assert property (p_hold_edge)
    else $error("A shift clock rise in hold mode changed the stages.");

  property p_up_entry;
    @(posedge ref_clk) disable iff (!clear_n)
      s_up_edge |=> parallel_out[0] == $past(right_serial_in);
  endproperty
  a_up_entry: assert property (p_up_entry)
    else $error("Upward shift did not take the right serial input into stage zero.");

  property p_down_entry;
    @(posedge ref_clk) disable iff (!clear_n)
      s_down_edge |=> parallel_out[shift_reg_pkg::TOP_STAGE] == $past(left_serial_in);
  endproperty
  a_down_entry: assert property (p_down_entry)
    else $error("Downward shift did not take the left serial input into the top stage.");

  property p_change_needs_rise;
    @(posedge ref_clk) disable iff (!clear_n)
      $changed(parallel_out) |-> $past(rise);
  endproperty
  a_change_needs_rise: assert property (p_change_needs_rise)
    else $error("Stages changed without a preceding shift clock rise.");

  property p_clock_high_steady;
    @(posedge ref_clk) disable iff (!clear_n)
      s_clock_high_three |-> $stable(parallel_out);
  endproperty
  a_clock_high_steady: assert property (p_clock_high_steady)
    else $error("Stages changed while the shift clock stayed high.");

endmodule

`default_nettype wire

// file: bench/mode_driver.sv
// Model of the logic that drives the modes, data and shift clock pin.
// Assumes one bench process calls its tasks; pins change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module mode_driver (
  // Clock
  input wire logic ref_clk,
  // Driven pins
  output logic master_clear_n,
  output logic shift_clock,
  output logic mode_select_low,
  output logic mode_select_high,
  output logic right_serial_in,
  output logic left_serial_in,
  output logic [7:0] parallel_in
);
  initial begin
    master_clear_n = 1'h1;
    shift_clock = 1'h0;
    {mode_select_high, mode_select_low} = 2'h0;
    {right_serial_in, left_serial_in} = 2'h0;
    parallel_in = 8'h00;
  end

  // Sets modes and data with the shift clock low.
  task automatic present(input logic [1:0] m, input logic r, input logic l,
                         input logic [7:0] d);
    @(negedge ref_clk);
    shift_clock = 1'h0;
    {mode_select_high, mode_select_low} = m;
    right_serial_in = r;
    left_serial_in = l;
    parallel_in = d;
  endtask

  // Gives one shift clock rise; inputs stay steady across it.
  task automatic pulse(input logic [1:0] m, input logic r, input logic l,
                       input logic [7:0] d);
    present(m, r, l, d);
    @(negedge ref_clk);
    shift_clock = 1'h1;
    @(negedge ref_clk);
    shift_clock = 1'h0;
  endtask

  // Gives one rise, then keeps the shift clock high for several cycles.
  task automatic long_pulse(input logic [1:0] m, input logic r, input logic l,
                            input logic [7:0] d);
    present(m, r, l, d);
    @(negedge ref_clk);
    shift_clock = 1'h1;
    repeat (4) @(negedge ref_clk);
    shift_clock = 1'h0;
  endtask

  // Drives the clear pin at a falling edge.
  task automatic clear(input logic level);
    @(negedge ref_clk);
    master_clear_n = level;
  endtask
endmodule

`default_nettype wire

// file: bench/universal_shift_reg_bench.sv
// Self-checking bench for the universal shift register.
// Assumes the mode_driver model drives all device inputs but ref_clk and rstn.
`timescale 1ns/1ps
`default_nettype none

module universal_shift_reg_bench;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic master_clear_n, shift_clock, mode_select_low, mode_select_high;
  logic right_serial_in, left_serial_in;
  logic [7:0] parallel_in, parallel_out;
  int err_count = 0;
  int check_count = 0;

  always #2.5 ref_clk = ~ref_clk;

  mode_driver u_mode_driver (.ref_clk(ref_clk), .master_clear_n(master_clear_n),
    .shift_clock(shift_clock), .mode_select_low(mode_select_low),
    .mode_select_high(mode_select_high), .right_serial_in(right_serial_in),
    .left_serial_in(left_serial_in), .parallel_in(parallel_in));

  universal_shift_reg u_universal_shift_reg (.ref_clk(ref_clk), .rstn(rstn),
    .master_clear_n(master_clear_n), .shift_clock(shift_clock),
    .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
    .right_serial_in(right_serial_in), .left_serial_in(left_serial_in),
    .parallel_in(parallel_in), .parallel_out(parallel_out));

  task automatic compare_out(input logic [7:0] exp);
    check_count++;
    if (parallel_out !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, parallel_out, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic test_load_and_shifts();
    u_mode_driver.pulse(2'h3, 1'h1, 1'h1, 8'ha5);
    compare_out(8'ha5);
    u_mode_driver.pulse(2'h1, 1'h1, 1'h0, 8'h00);
    compare_out(8'h4b);
    u_mode_driver.pulse(2'h1, 1'h0, 1'h1, 8'hff);
    compare_out(8'h96);
    u_mode_driver.pulse(2'h2, 1'h0, 1'h1, 8'h00);
    compare_out(8'hcb);
    u_mode_driver.pulse(2'h2, 1'h1, 1'h0, 8'hff);
    compare_out(8'h65);
  endtask

  task automatic test_hold_and_no_rise();
    u_mode_driver.pulse(2'h0, 1'h1, 1'h1, 8'hff);
    compare_out(8'h65);
    u_mode_driver.present(2'h3, 1'h0, 1'h0, 8'h3c);
    repeat (4) @(negedge ref_clk);
    compare_out(8'h65);
    u_mode_driver.long_pulse(2'h1, 1'h1, 1'h1, 8'h00);
    compare_out(8'hcb);
  endtask

  task automatic test_clear();
    u_mode_driver.clear(1'h0);
    #1;
    compare_out(8'h00);
    u_mode_driver.pulse(2'h3, 1'h1, 1'h1, 8'hff);
    compare_out(8'h00);
    u_mode_driver.clear(1'h1);
    u_mode_driver.pulse(2'h3, 1'h0, 1'h0, 8'h5a);
    compare_out(8'h5a);
  endtask

  initial begin
    #20000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (2) @(negedge ref_clk);
    compare_out(8'h00);
    rstn = 1'h1;
    test_load_and_shifts();
    test_hold_and_no_rise();
    test_clear();
    finish_test();
  end
endmodule

`default_nettype wire
